// file: design/src_defines.vh
// Purpose: Shared constants of the speed reference conditioner.
// Assumes: Frequencies in 0.1 Hz, limits in 0.1 %, times in 0.1 s.
// Notes:   Offsets are APB byte addresses of aligned 32-bit words.
`ifndef SRC_DEFINES_VH
`define SRC_DEFINES_VH

`define SRC_OFF_ACCEL_A      6'h00
`define SRC_OFF_DECEL_A      6'h04
`define SRC_OFF_ACCEL_B      6'h08
`define SRC_OFF_DECEL_B      6'h0c
`define SRC_OFF_FAST_STOP    6'h10
`define SRC_OFF_SWITCHOVER   6'h14
`define SRC_OFF_MFI_FUNC     6'h18
`define SRC_OFF_UPPER_LIMIT  6'h1c
`define SRC_OFF_LOWER_LIMIT  6'h20
`define SRC_OFF_MASTER_FLOOR 6'h24
`define SRC_OFF_SKIP_ONE     6'h28
`define SRC_OFF_SKIP_TWO     6'h2c
`define SRC_OFF_SKIP_THREE   6'h30
`define SRC_OFF_SKIP_WIDTH   6'h34
`define SRC_OFF_MAX_FREQ     6'h38
`define SRC_OFF_STATUS       6'h3c

`define SRC_RST_ACCEL        16'h012c
`define SRC_RST_DECEL        16'h012c
`define SRC_RST_FAST_STOP    16'h0064
`define SRC_RST_SWITCHOVER   16'h0000
`define SRC_RST_MFI_FUNC     32'h0000_0000
`define SRC_RST_UPPER_LIMIT  16'h03e8
`define SRC_RST_LOWER_LIMIT  16'h0000
`define SRC_RST_MASTER_FLOOR 16'h0000
`define SRC_RST_SKIP_CENTRE  16'h0000
`define SRC_RST_SKIP_WIDTH   16'h000a
`define SRC_RST_MAX_FREQ     16'h0258

`define SRC_MFI_RAMP_PAIR_B  8'h07
`define SRC_MFI_FS_CLOSE     8'h0f
`define SRC_MFI_FS_OPEN      8'h11

`define SRC_ST_PAIR_B_BIT    16
`define SRC_ST_FAST_STOP_BIT 17
`define SRC_ST_RUN_BIT       18
`define SRC_ST_RUN_OK_BIT    19

`define SRC_PERMILLE         32'd1000
`define SRC_MS_PER_TIME_UNIT 24'd100
`define SRC_CLK_PERIOD_NS    4
`define SRC_RAMP_TICK_NS     1000000
`define SRC_RAMP_TICK_CYCLES (`SRC_RAMP_TICK_NS / `SRC_CLK_PERIOD_NS)

`endif

// file: design/src_speed_ref_cond.v
// Purpose: Speed command limiting, jump bands, ramp pair choice and fast stop.
// Assumes: APB slave on pclk, digital inputs and run command are pins.
// Notes:   One ramp step is 0.1 Hz, the ramp is timed on a 1 ms tick.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "src_defines.vh"

module src_speed_ref_cond #(
    parameter N_INPUTS    = 4,
    parameter TICK_CYCLES = `SRC_RAMP_TICK_CYCLES
) (
    input  wire                pclk,
    input  wire                presetn,
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [7:0]          paddr,
    input  wire [31:0]         pwdata,
    output wire                pready,
    output wire                pslverr,
    output reg  [31:0]         prdata,
    input  wire [15:0]         speed_cmd,
    input  wire                cmd_is_master_analog,
    input  wire                run_cmd_pin,
    input  wire [N_INPUTS-1:0] digital_in_pin,
    output reg  [15:0]         out_freq_ff,
    output reg  [15:0]         target_freq_ff,
    output wire                ramp_pair_b,
    output wire                fast_stop_active,
    output wire                run_permitted
);

    reg  [15:0]         accel_time_pair_a_ff;
    reg  [15:0]         decel_time_pair_a_ff;
    reg  [15:0]         accel_time_pair_b_ff;
    reg  [15:0]         decel_time_pair_b_ff;
    reg  [15:0]         fast_stop_decel_time_ff;
    reg  [15:0]         ramp_pair_switchover_freq_ff;
    reg  [31:0]         multifunction_input_function_ff;
    reg  [15:0]         reference_upper_limit_ff;
    reg  [15:0]         reference_lower_limit_ff;
    reg  [15:0]         master_reference_floor_ff;
    reg  [15:0]         skip_band_centre_one_ff;
    reg  [15:0]         skip_band_centre_two_ff;
    reg  [15:0]         skip_band_centre_three_ff;
    reg  [15:0]         skip_band_width_ff;
    reg  [15:0]         max_output_frequency_ff;
    reg  [N_INPUTS-1:0] din_meta_ff;
    reg  [N_INPUTS-1:0] din_ff;
    reg                 run_meta_ff;
    reg                 run_ff;
    reg                 fast_stop_ff;
    reg  [17:0]         tick_cnt_ff;
    reg  [23:0]         ramp_acc_ff;
    reg                 pair_b;
    reg                 fs_trigger;
    reg  [15:0]         cmd_floored;
    reg  [15:0]         cmd_limited;
    reg  [15:0]         cmd_skipped;
    reg  [15:0]         ramp_time;
    reg  [15:0]         nxt_target;
    reg  [31:0]         rd_word;
    reg                 addr_hit;

    wire        setup_phase = psel & ~penable;
    wire        wr_access   = psel & penable & pwrite;
    wire [5:0]  reg_addr    = paddr[5:0];
    wire        tick        = (tick_cnt_ff == 18'd0);
    wire [15:0] upper_freq  = pct_to_freq(max_output_frequency_ff, reference_upper_limit_ff);
    wire [15:0] lower_freq  = pct_to_freq(max_output_frequency_ff, reference_lower_limit_ff);
    wire [15:0] floor_freq  = pct_to_freq(max_output_frequency_ff, master_reference_floor_ff);
    wire [15:0] half_width  = {1'b0, skip_band_width_ff[15:1]};
    wire        rising      = (target_freq_ff > out_freq_ff);
    wire [23:0] ramp_thr    = ramp_threshold(ramp_time);

    function [15:0] pct_to_freq;
        input [15:0] fmax;
        input [15:0] permille;
        reg   [31:0] prod;
        reg   [31:0] quot;
        begin
            prod        = {16'h0000, fmax} * {16'h0000, permille};
            quot        = prod / `SRC_PERMILLE;
            // The quotient is not bounded by the largest frequency; only its low 16 bits are kept.
            pct_to_freq = quot[15:0];
        end
    endfunction

    function [23:0] ramp_threshold;
        input [15:0] t;
        reg   [31:0] prod;
        begin
            prod           = {16'h0000, t} * {8'h00, `SRC_MS_PER_TIME_UNIT};
            ramp_threshold = prod[23:0];
        end
    endfunction

    // A centre of zero leaves its band disabled. Which edge the command is
    // held at depends on which side the previous reference lay.
    function [15:0] skip_band;
        input [15:0] ref_in;
        input [15:0] centre;
        input [15:0] half;
        input [15:0] prev;
        reg   [15:0] lo;
        reg   [15:0] hi;
        begin
            lo = (centre > half) ? centre - half : 16'h0000;
            hi = centre + half;
            skip_band = ref_in;
            if (centre != 16'h0000 && ref_in > lo && ref_in < hi) begin
                skip_band = (prev >= hi) ? hi : lo;
            end
        end
    endfunction

    function mfi_match;
        input [31:0]         funcs;
        input [N_INPUTS-1:0] levels;
        input [7:0]          code;
        input                want;
        integer              k;
        begin
            mfi_match = 1'b0;
            for (k = 0; k < N_INPUTS; k = k + 1) begin
                if (funcs[k*8 +: 8] == code && levels[k] == want) begin
                    mfi_match = 1'b1;
                end
            end
        end
    endfunction

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_meta_ff <= {N_INPUTS{1'b0}};
            din_ff      <= {N_INPUTS{1'b0}};
            run_meta_ff <= 1'b0;
            run_ff      <= 1'b0;
        end else begin
            din_meta_ff <= digital_in_pin;
            din_ff      <= din_meta_ff;
            run_meta_ff <= run_cmd_pin;
            run_ff      <= run_meta_ff;
        end
    end

    always @* begin
        pair_b = mfi_match(multifunction_input_function_ff, din_ff, `SRC_MFI_RAMP_PAIR_B, 1'b1) |
                 (ramp_pair_switchover_freq_ff != 16'h0000 && out_freq_ff < ramp_pair_switchover_freq_ff);
        fs_trigger = mfi_match(multifunction_input_function_ff, din_ff, `SRC_MFI_FS_CLOSE, 1'b1) |
                     mfi_match(multifunction_input_function_ff, din_ff, `SRC_MFI_FS_OPEN, 1'b0);
        cmd_floored = (cmd_is_master_analog && speed_cmd < floor_freq) ? floor_freq : speed_cmd;
        cmd_limited = (cmd_floored < lower_freq) ? lower_freq : cmd_floored;
        if (cmd_limited > upper_freq) begin
            cmd_limited = upper_freq;
        end
        cmd_skipped = skip_band(cmd_limited, skip_band_centre_one_ff, half_width, target_freq_ff);
        cmd_skipped = skip_band(cmd_skipped, skip_band_centre_two_ff, half_width, target_freq_ff);
        cmd_skipped = skip_band(cmd_skipped, skip_band_centre_three_ff, half_width, target_freq_ff);
        nxt_target = (run_ff && !fast_stop_ff) ? cmd_skipped : 16'h0000;
        if (fast_stop_ff) begin
            ramp_time = fast_stop_decel_time_ff;
        end else if (rising) begin
            ramp_time = pair_b ? accel_time_pair_b_ff : accel_time_pair_a_ff;
        end else begin
            ramp_time = pair_b ? decel_time_pair_b_ff : decel_time_pair_a_ff;
        end
    end

    // Runs of whole steps follow each tick; a tick carries at most 656
    // steps, far fewer than the cycles between ticks, so none are lost.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_ff    <= 18'd0;
            ramp_acc_ff    <= 24'd0;
            out_freq_ff    <= 16'h0000;
            target_freq_ff <= 16'h0000;
            fast_stop_ff   <= 1'b0;
        end else begin
            tick_cnt_ff    <= (tick_cnt_ff == TICK_CYCLES - 1) ? 18'd0 : tick_cnt_ff + 18'd1;
            target_freq_ff <= nxt_target;
            if (fs_trigger) begin
                fast_stop_ff <= 1'b1;
            end else if (out_freq_ff == 16'h0000 && !run_ff) begin
                fast_stop_ff <= 1'b0;
            end
            if (out_freq_ff == target_freq_ff) begin
                ramp_acc_ff <= 24'd0;
            end else if (ramp_thr == 24'd0) begin
                out_freq_ff <= target_freq_ff;
                ramp_acc_ff <= 24'd0;
            end else if (ramp_acc_ff >= ramp_thr) begin
                out_freq_ff <= rising ? out_freq_ff + 16'h0001 : out_freq_ff - 16'h0001;
                ramp_acc_ff <= ramp_acc_ff - ramp_thr;
            end else if (tick) begin
                ramp_acc_ff <= ramp_acc_ff + {8'h00, max_output_frequency_ff};
            end
        end
    end

    assign ramp_pair_b      = pair_b;
    assign fast_stop_active = fast_stop_ff;
    assign run_permitted    = ~fast_stop_ff;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accel_time_pair_a_ff            <= `SRC_RST_ACCEL;
            decel_time_pair_a_ff            <= `SRC_RST_DECEL;
            accel_time_pair_b_ff            <= `SRC_RST_ACCEL;
            decel_time_pair_b_ff            <= `SRC_RST_DECEL;
            fast_stop_decel_time_ff         <= `SRC_RST_FAST_STOP;
            ramp_pair_switchover_freq_ff    <= `SRC_RST_SWITCHOVER;
            multifunction_input_function_ff <= `SRC_RST_MFI_FUNC;
            reference_upper_limit_ff        <= `SRC_RST_UPPER_LIMIT;
            reference_lower_limit_ff        <= `SRC_RST_LOWER_LIMIT;
            master_reference_floor_ff       <= `SRC_RST_MASTER_FLOOR;
            skip_band_centre_one_ff         <= `SRC_RST_SKIP_CENTRE;
            skip_band_centre_two_ff         <= `SRC_RST_SKIP_CENTRE;
            skip_band_centre_three_ff       <= `SRC_RST_SKIP_CENTRE;
            skip_band_width_ff              <= `SRC_RST_SKIP_WIDTH;
            max_output_frequency_ff         <= `SRC_RST_MAX_FREQ;
        end else if (wr_access) begin
            case (reg_addr)
                `SRC_OFF_ACCEL_A:      accel_time_pair_a_ff            <= pwdata[15:0];
                `SRC_OFF_DECEL_A:      decel_time_pair_a_ff            <= pwdata[15:0];
                `SRC_OFF_ACCEL_B:      accel_time_pair_b_ff            <= pwdata[15:0];
                `SRC_OFF_DECEL_B:      decel_time_pair_b_ff            <= pwdata[15:0];
                `SRC_OFF_FAST_STOP:    fast_stop_decel_time_ff         <= pwdata[15:0];
                `SRC_OFF_SWITCHOVER:   ramp_pair_switchover_freq_ff    <= pwdata[15:0];
                `SRC_OFF_MFI_FUNC:     multifunction_input_function_ff <= pwdata;
                `SRC_OFF_UPPER_LIMIT:  reference_upper_limit_ff        <= pwdata[15:0];
                `SRC_OFF_LOWER_LIMIT:  reference_lower_limit_ff        <= pwdata[15:0];
                `SRC_OFF_MASTER_FLOOR: master_reference_floor_ff       <= pwdata[15:0];
                `SRC_OFF_SKIP_ONE:     skip_band_centre_one_ff         <= pwdata[15:0];
                `SRC_OFF_SKIP_TWO:     skip_band_centre_two_ff         <= pwdata[15:0];
                `SRC_OFF_SKIP_THREE:   skip_band_centre_three_ff       <= pwdata[15:0];
                `SRC_OFF_SKIP_WIDTH:   skip_band_width_ff              <= pwdata[15:0];
                `SRC_OFF_MAX_FREQ:     max_output_frequency_ff         <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    always @* begin
        addr_hit = 1'b1;
        rd_word  = 32'h0000_0000;
        case (reg_addr)
            `SRC_OFF_ACCEL_A:      rd_word[15:0] = accel_time_pair_a_ff;
            `SRC_OFF_DECEL_A:      rd_word[15:0] = decel_time_pair_a_ff;
            `SRC_OFF_ACCEL_B:      rd_word[15:0] = accel_time_pair_b_ff;
            `SRC_OFF_DECEL_B:      rd_word[15:0] = decel_time_pair_b_ff;
            `SRC_OFF_FAST_STOP:    rd_word[15:0] = fast_stop_decel_time_ff;
            `SRC_OFF_SWITCHOVER:   rd_word[15:0] = ramp_pair_switchover_freq_ff;
            `SRC_OFF_MFI_FUNC:     rd_word       = multifunction_input_function_ff;
            `SRC_OFF_UPPER_LIMIT:  rd_word[15:0] = reference_upper_limit_ff;
            `SRC_OFF_LOWER_LIMIT:  rd_word[15:0] = reference_lower_limit_ff;
            `SRC_OFF_MASTER_FLOOR: rd_word[15:0] = master_reference_floor_ff;
            `SRC_OFF_SKIP_ONE:     rd_word[15:0] = skip_band_centre_one_ff;
            `SRC_OFF_SKIP_TWO:     rd_word[15:0] = skip_band_centre_two_ff;
            `SRC_OFF_SKIP_THREE:   rd_word[15:0] = skip_band_centre_three_ff;
            `SRC_OFF_SKIP_WIDTH:   rd_word[15:0] = skip_band_width_ff;
            `SRC_OFF_MAX_FREQ:     rd_word[15:0] = max_output_frequency_ff;
            `SRC_OFF_STATUS: begin
                rd_word[15:0]                 = out_freq_ff;
                rd_word[`SRC_ST_PAIR_B_BIT]    = pair_b;
                rd_word[`SRC_ST_FAST_STOP_BIT] = fast_stop_ff;
                rd_word[`SRC_ST_RUN_BIT]       = run_ff;
                rd_word[`SRC_ST_RUN_OK_BIT]    = ~fast_stop_ff;
            end
            default: addr_hit = 1'b0;
        endcase
        if (paddr[7:6] != 2'b00 || paddr[1:0] != 2'b00) begin
            addr_hit = 1'b0;
            rd_word  = 32'h0000_0000;
        end
    end

    // Read data is captured in the setup cycle so that the access cycle
    // can finish with no wait state.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase) begin
            prdata <= rd_word;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_hit;

endmodule // src_speed_ref_cond

`default_nettype wire

// file: sim/src_ref_cond_props.sv
// Purpose: Port-level properties of the speed reference conditioner.
// Assumes: One clock domain, pins pass two synchroniser flops.
// Notes:   Attached to the design by the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module src_ref_cond_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        run_cmd_pin,
    input wire logic [15:0] out_freq_ff,
    input wire logic [15:0] target_freq_ff,
    input wire logic        fast_stop_active,
    input wire logic        run_permitted
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_ready_in_access: assert property (psel && penable |-> pready)
        else $error("access not answered");
    chk_err_in_setup: assert property (psel && !penable |-> !pslverr)
        else $error("error flag in setup cycle");
    chk_err_unmapped: assert property (psel && penable && (paddr > 8'h3c || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unmapped access without error");
    chk_err_mapped: assert property (psel && penable && paddr <= 8'h3c && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access with error");
    chk_fs_permit: assert property (run_permitted != fast_stop_active)
        else $error("run permission not inverse of fast stop");
    chk_fs_zero_target: assert property (fast_stop_active && $past(fast_stop_active) |-> target_freq_ff == 16'h0)
        else $error("target not zero while fast stop latched");
    chk_fs_hold: assert property (fast_stop_active && out_freq_ff != 16'h0 |=> fast_stop_active)
        else $error("fast stop released before standstill");
    chk_fs_release: assert property ($fell(fast_stop_active) |-> out_freq_ff == 16'h0 && !$past(run_cmd_pin, 3))
        else $error("fast stop released while running");
    chk_run_low_zero: assert property (!run_cmd_pin [*4] |-> target_freq_ff == 16'h0)
        else $error("target not zero with run removed");
    chk_ramp_up: assert property (out_freq_ff > $past(out_freq_ff) |-> $past(out_freq_ff) < $past(target_freq_ff))
        else $error("output rose above target");
    chk_ramp_down: assert property (out_freq_ff < $past(out_freq_ff) |-> $past(out_freq_ff) > $past(target_freq_ff))
        else $error("output fell below target");
endmodule // src_ref_cond_props

bind src_speed_ref_cond src_ref_cond_props u_src_ref_cond_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .run_cmd_pin(run_cmd_pin), .out_freq_ff(out_freq_ff),
    .target_freq_ff(target_freq_ff), .fast_stop_active(fast_stop_active), .run_permitted(run_permitted));
`default_nettype wire

// file: sim/src_drive_model.sv
// Purpose: Far-side model: run switch and multifunction input contacts.
// Assumes: Bench requests reach the pins one edge later, as contacts.
// Notes:   Contacts are levels, so they hold between requests.
`timescale 1ns/1ps
`default_nettype none
module src_drive_model (
    input  wire logic       pclk,
    input  wire logic       run_req,
    input  wire logic [3:0] contact_req,
    output var  logic       run_cmd_pin,
    output var  logic [3:0] digital_in_pin
);
    always @(posedge pclk) begin
        run_cmd_pin    <= run_req;
        digital_in_pin <= contact_req;
    end
endmodule // src_drive_model
`default_nettype wire

// file: sim/src_speed_ref_cond_tb.sv
// Purpose: Self-checking bench of the speed reference conditioner.
// Assumes: Ramp tick shortened to 10 cycles.
// Notes:   Input 2 idles closed so that an opening contact can be tested.
`timescale 1ns/1ps
`default_nettype none
module src_speed_ref_cond_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        run_req = 1'b0;
    logic        is_analog = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] speed_cmd = 16'h0;
    logic [3:0]  contact_req = 4'h4;
    logic [31:0] prdata, rd;
    logic [15:0] out_freq_ff, target_freq_ff;
    logic [3:0]  digital_in_pin;
    logic        pready, pslverr, err, ramp_pair_b, fast_stop_active, run_permitted, run_cmd_pin;
    int          miscompares = 0;
    int          checks_done = 0;
    int          k;
    logic [31:0] dflt [15] = '{32'h12c, 32'h12c, 32'h12c, 32'h12c, 32'h64, 32'h0, 32'h0, 32'h3e8,
                              32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'ha, 32'h258};

    always #2 pclk = ~pclk;

    src_speed_ref_cond #(.N_INPUTS(4), .TICK_CYCLES(10)) u_src_speed_ref_cond (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .speed_cmd(speed_cmd), .cmd_is_master_analog(is_analog), .run_cmd_pin(run_cmd_pin),
        .digital_in_pin(digital_in_pin), .out_freq_ff(out_freq_ff), .target_freq_ff(target_freq_ff),
        .ramp_pair_b(ramp_pair_b), .fast_stop_active(fast_stop_active), .run_permitted(run_permitted));
    src_drive_model u_src_drive_model (.pclk(pclk), .run_req(run_req), .contact_req(contact_req),
        .run_cmd_pin(run_cmd_pin), .digital_in_pin(digital_in_pin));

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        checks_done++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            miscompares++;
            $display("BAD %0t got %h outside %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic cmd(input logic [15:0] v, input logic [15:0] exp);
        speed_cmd <= v;
        repeat (3) @(posedge pclk);
        check(32'(target_freq_ff), 32'(exp));
    endtask

    task automatic wait_out(input logic [15:0] v);
        for (int n = 0; n < 8000 && out_freq_ff !== v; n++) @(posedge pclk);
        check(32'(out_freq_ff), 32'(v));
    endtask

    task automatic final_report;
        if (miscompares == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge pclk);
        miscompares++;
        final_report;
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (k = 0; k < 15; k++) rchk(8'(k * 4), dflt[k]);
        apb(1'b1, 8'h3c, 32'hffff_ffff);
        check(32'(err), 32'h0);
        rchk(8'h3c, 32'h8_0000);
        rchk(8'h40, 32'h0);
        check(32'(err), 32'h1);
        apb(1'b1, 8'h00, 32'ha);
        apb(1'b1, 8'h04, 32'ha);
        run_req <= 1'b1;
        apb(1'b1, 8'h1c, 32'h1f4);
        cmd(16'h190, 16'h12c);
        apb(1'b1, 8'h38, 32'h190);
        cmd(16'h190, 16'hc8);
        apb(1'b1, 8'h38, 32'h258);
        apb(1'b1, 8'h1c, 32'h3e8);
        apb(1'b1, 8'h20, 32'h64);
        cmd(16'h14, 16'h3c);
        apb(1'b1, 8'h24, 32'hc8);
        is_analog <= 1'b1;
        cmd(16'h32, 16'h78);
        is_analog <= 1'b0;
        cmd(16'h32, 16'h3c);
        apb(1'b1, 8'h20, 32'h0);
        apb(1'b1, 8'h24, 32'h0);
        apb(1'b1, 8'h34, 32'h14);
        for (k = 0; k < 3; k++) apb(1'b1, 8'(8'h28 + k * 4), 32'(100 * (k + 1)));
        for (k = 1; k <= 3; k++) begin
            cmd(16'(100 * k - 50), 16'(100 * k - 50));
            cmd(16'(100 * k), 16'(100 * k - 10));
            cmd(16'(100 * k + 15), 16'(100 * k + 15));
            cmd(16'(100 * k), 16'(100 * k + 10));
            cmd(16'(100 * k - 15), 16'(100 * k - 15));
        end
        for (k = 0; k < 3; k++) apb(1'b1, 8'(8'h28 + k * 4), 32'h0);
        run_req <= 1'b0;
        wait_out(16'h0);
        cmd(16'h12c, 16'h0);
        run_req <= 1'b1;
        repeat (1004) @(posedge pclk);
        check_rng(out_freq_ff, 16'h39, 16'h3e);
        wait_out(16'h12c);
        check(32'(ramp_pair_b), 32'h0);
        apb(1'b1, 8'h18, 32'h7);
        contact_req <= 4'h5;
        repeat (4) @(posedge pclk);
        check(32'(ramp_pair_b), 32'h1);
        contact_req <= 4'h4;
        repeat (4) @(posedge pclk);
        check(32'(ramp_pair_b), 32'h0);
        apb(1'b1, 8'h14, 32'h190);
        check(32'(ramp_pair_b), 32'h1);
        apb(1'b1, 8'h14, 32'h0);
        apb(1'b1, 8'h10, 32'ha);
        apb(1'b1, 8'h18, 32'h11_0f00);
        contact_req <= 4'h6;
        repeat (2) @(posedge pclk);
        contact_req <= 4'h4;
        repeat (6) @(posedge pclk);
        check(32'(fast_stop_active), 32'h1);
        check(32'(run_permitted), 32'h0);
        repeat (1000) @(posedge pclk);
        check_rng(out_freq_ff, 16'hec, 16'hf4);
        wait_out(16'h0);
        repeat (10) @(posedge pclk);
        check(32'(fast_stop_active), 32'h1);
        run_req <= 1'b0;
        repeat (6) @(posedge pclk);
        check(32'(fast_stop_active), 32'h0);
        run_req <= 1'b1;
        repeat (6) @(posedge pclk);
        check(32'(target_freq_ff), 32'h12c);
        contact_req <= 4'h0;
        repeat (6) @(posedge pclk);
        check(32'(fast_stop_active), 32'h1);
        wait_out(16'h0);
        final_report;
    end
endmodule // src_speed_ref_cond_tb
`default_nettype wire
